// [target_port.sv]
`include "target_map.svh"

// Contract
// - accept 100 kHz, 400 kHz and 2.6 MHz
// - address sampled on rising clock, last bit direction
// - acknowledge own address on ninth pulse
// - data moves low; high-phase change is start/stop
// - clock low 28 ms resets the state machine
// - strap selects one of three addresses
// - strap sampled every transfer, set beforehand
// - bytes travel most significant bit first
// - first written byte loads pointer
// - two data bytes stored high first, acknowledged
// - read returns register at last pointer
// - upper byte, controller ack, then lower byte
// - pointer kept across reads until rewritten
// - high-speed code unacknowledged, filters narrowed
// - repeated starts keep high-speed mode, stop ends
// - burst mode advances pointer per register read
// - stop after burst restores original pointer
module target_port #(
	parameter int TOUT_CYC = `TOUT_MS * `NS_PER_MS / `CLK_NS
) (
	// clocks and reset
	input  wire logic                 clk,
	input  wire logic                 rstn,
	input  wire logic                 scl,
	// serial data pin
	input  wire logic                 sda_i,
	output logic                      sda_o,
	output logic                      sda_oe,
	// address strap
	input  wire logic [1:0]           addr_strap,
	// register side
	input  wire logic                 burst_en,
	input  wire target_pkg::word_type rd_data,
	output target_pkg::byte_type      rd_addr,
	output logic                      wr_en,
	output target_pkg::byte_type      wr_addr,
	output target_pkg::word_type      wr_data,
	// filter mode
	output logic                      hs_mode
);
	import target_pkg::*;

	localparam int TW = $clog2(TOUT_CYC + 1);

	function automatic logic settle(input logic [2:0] h, input logic hs, input logic cur);
		if (hs)
			return h[0];
		if ((&h) || (~|h))
			return h[0];
		return cur;
	endfunction : settle

	function automatic logic [6:0] addr_of(input logic [1:0] s);
		case (s)
			`STRAP_GND: return `ADDR_GND;
			`STRAP_VDD: return `ADDR_VDD;
			`STRAP_SDA: return `ADDR_SDA;
			default:    return `ADDR_SCL;
		endcase
	endfunction : addr_of

	// ----------------------------------------
	// link domain
	// ----------------------------------------
	// sda is captured on the bus clock itself so high-speed bits are sampled exactly at the edge
	logic bit_r;
	logic tog_r;

	always_ff @(posedge scl or negedge rstn) begin
		if (!rstn) begin
			bit_r <= 1'b0;
			tog_r <= 1'b0;
		end else begin
			bit_r <= sda_i;
			tog_r <= ~tog_r;
		end
	end

	// ----------------------------------------
	// crossings and pin synchronisers
	// ----------------------------------------
	logic       tog_s1, tog_s2, tog_s3, tog_s4;
	logic       bit_s1, bit_s2;
	logic       scl_s1, scl_s2, sda_s1, sda_s2;
	logic [1:0] strap_s1, strap_s2;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tog_s1   <= 1'b0;
			tog_s2   <= 1'b0;
			tog_s3   <= 1'b0;
			tog_s4   <= 1'b0;
			bit_s1   <= 1'b0;
			bit_s2   <= 1'b0;
			scl_s1   <= 1'b1;
			scl_s2   <= 1'b1;
			sda_s1   <= 1'b1;
			sda_s2   <= 1'b1;
			strap_s1 <= `STRAP_GND;
			strap_s2 <= `STRAP_GND;
		end else begin
			tog_s1   <= tog_r;
			tog_s2   <= tog_s1;
			tog_s3   <= tog_s2;
			tog_s4   <= tog_s3;
			bit_s1   <= bit_r;
			bit_s2   <= bit_s1;
			scl_s1   <= scl;
			scl_s2   <= scl_s1;
			sda_s1   <= sda_i;
			sda_s2   <= sda_s1;
			strap_s1 <= addr_strap;
			strap_s2 <= strap_s1;
		end
	end

	// ----------------------------------------
	// spike filters and condition detect
	// ----------------------------------------
	logic [2:0] scl_h_r, sda_h_r;
	logic       scl_f_r, sda_f_r, scl_q_r, sda_q_r;
	logic       hs_r;

	// both lines pass through identical filters of equal delay so start/stop ordering against clock falls is kept
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			scl_h_r <= 3'h7;
			sda_h_r <= 3'h7;
			scl_f_r <= 1'b1;
			sda_f_r <= 1'b1;
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			scl_h_r <= {scl_h_r[1:0], scl_s2};
			sda_h_r <= {sda_h_r[1:0], sda_s2};
			scl_f_r <= settle(scl_h_r, hs_r, scl_f_r);
			sda_f_r <= settle(sda_h_r, hs_r, sda_f_r);
			scl_q_r <= scl_f_r;
			sda_q_r <= sda_f_r;
		end
	end

	logic start_det, stop_det, fall, rise;

	assign start_det = scl_f_r && scl_q_r && sda_q_r && !sda_f_r;
	assign stop_det  = scl_f_r && scl_q_r && !sda_q_r && sda_f_r;
	assign fall      = scl_q_r && !scl_f_r;
	assign rise      = tog_s3 ^ tog_s4;

	// ----------------------------------------
	// lockup timeout
	// ----------------------------------------
	logic [TW-1:0] tout_r;
	logic          tout_hit;
	state_type     state_r;

	assign tout_hit = !scl_f_r && (tout_r == TW'(TOUT_CYC - 1));

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			tout_r <= '0;
		else if (scl_f_r || state_r == ST_IDLE)
			tout_r <= '0;
		else if (!tout_hit)
			tout_r <= tout_r + 1'b1;
	end

	// ----------------------------------------
	// byte engine
	// ----------------------------------------
	logic [7:0] sh_r, tx_r, wr_hi_r, ptr_r, save_r;
	logic [2:0] cnt_r, idx_r;
	logic [6:0] dev_addr_r;
	logic [15:0] word_r;
	logic       nine_r, ack_yes_r, rw_r, hi_r, acked_r, burst_act_r;
	logic       sda_oe_r, sda_o_r, wr_en_r;
	logic [7:0] wr_addr_r;
	logic [15:0] wr_data_r;
	logic [7:0] byte_now;
	logic       last, got_byte, ptr_load, burst_inc, restore, hs_seen;

	assign byte_now  = {sh_r[6:0], bit_s2};
	assign last      = rise && (cnt_r == `LAST_BIT);
	assign got_byte  = (state_r == ST_RECV) && last;
	assign ptr_load  = got_byte && (idx_r == `IDX_PTR);
	assign burst_inc = (state_r == ST_SEND) && last && !hi_r && burst_en;
	assign restore   = stop_det && burst_act_r;
	assign hs_seen   = got_byte && (idx_r == `IDX_ADDR) && (byte_now[7:3] == `HS_CODE);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_r    <= ST_IDLE;
			sh_r       <= 8'h00;
			tx_r       <= 8'h00;
			wr_hi_r    <= 8'h00;
			word_r     <= 16'h0000;
			cnt_r      <= 3'h0;
			idx_r      <= `IDX_ADDR;
			dev_addr_r <= `ADDR_GND;
			nine_r     <= 1'b0;
			ack_yes_r  <= 1'b0;
			rw_r       <= 1'b0;
			hi_r       <= 1'b1;
			acked_r    <= 1'b0;
			sda_oe_r   <= 1'b0;
			wr_en_r    <= 1'b0;
			wr_addr_r  <= `PTR_RST;
			wr_data_r  <= 16'h0000;
		end else begin
			wr_en_r <= 1'b0;
			if (tout_hit || stop_det) begin
				state_r  <= ST_IDLE;
				sda_oe_r <= 1'b0;
			end else if (start_det) begin
				state_r    <= ST_RECV;
				idx_r      <= `IDX_ADDR;
				cnt_r      <= 3'h0;
				sda_oe_r   <= 1'b0;
				dev_addr_r <= addr_of(strap_s2);
			end else begin
				case (state_r)
					ST_RECV: begin
						if (rise) begin
							sh_r  <= byte_now;
							cnt_r <= cnt_r + 1'b1;
						end
						if (last) begin
							state_r   <= ST_ACK;
							nine_r    <= 1'b0;
							ack_yes_r <= 1'b1;
							case (idx_r)
								`IDX_ADDR: begin
									ack_yes_r <= (byte_now[7:1] == dev_addr_r);
									rw_r      <= byte_now[0];
								end
								`IDX_WHI: wr_hi_r <= byte_now;
								`IDX_WLO: begin
									wr_en_r   <= 1'b1;
									wr_addr_r <= ptr_r;
									wr_data_r <= {wr_hi_r, byte_now};
								end
								`IDX_OVER: ack_yes_r <= 1'b0;
								default: ;
							endcase
						end
					end
					ST_ACK: begin
						if (rise)
							nine_r <= 1'b1;
						if (fall && !nine_r)
							sda_oe_r <= ack_yes_r;
						if (fall && nine_r) begin
							cnt_r <= 3'h0;
							if (!ack_yes_r) begin
								state_r  <= ST_SKIP;
								sda_oe_r <= 1'b0;
							end else if (idx_r == `IDX_ADDR && rw_r) begin
								state_r  <= ST_SEND;
								hi_r     <= 1'b1;
								word_r   <= rd_data;
								tx_r     <= rd_data[15:8];
								sda_oe_r <= ~rd_data[15];
							end else begin
								state_r  <= ST_RECV;
								sda_oe_r <= 1'b0;
								if (idx_r != `IDX_OVER)
									idx_r <= idx_r + 1'b1;
							end
						end
					end
					ST_SEND: begin
						if (rise) begin
							cnt_r <= cnt_r + 1'b1;
							tx_r  <= {tx_r[6:0], 1'b0};
						end
						if (fall)
							sda_oe_r <= ~tx_r[7];
						if (last) begin
							state_r <= ST_CACK;
							nine_r  <= 1'b0;
						end
					end
					ST_CACK: begin
						if (fall && !nine_r)
							sda_oe_r <= 1'b0;
						if (rise) begin
							nine_r  <= 1'b1;
							acked_r <= !bit_s2;
						end
						if (fall && nine_r) begin
							cnt_r <= 3'h0;
							if (!acked_r) begin
								state_r <= ST_SKIP;
							end else if (hi_r) begin
								state_r  <= ST_SEND;
								hi_r     <= 1'b0;
								tx_r     <= word_r[7:0];
								sda_oe_r <= ~word_r[7];
							end else begin
								state_r  <= ST_SEND;
								hi_r     <= 1'b1;
								word_r   <= rd_data;
								tx_r     <= rd_data[15:8];
								sda_oe_r <= ~rd_data[15];
							end
						end
					end
					ST_IDLE, ST_SKIP: ;
					default: begin
						state_r  <= ST_IDLE;
						sda_oe_r <= 1'b0;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// register pointer
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ptr_r       <= `PTR_RST;
			save_r      <= `PTR_RST;
			burst_act_r <= 1'b0;
		end else begin
			if (ptr_load)
				ptr_r <= byte_now;
			else if (restore)
				ptr_r <= save_r;
			else if (burst_inc)
				ptr_r <= ptr_r + 1'b1;
			if (stop_det || ptr_load)
				burst_act_r <= 1'b0;
			else if (burst_inc && !burst_act_r) begin
				burst_act_r <= 1'b1;
				save_r      <= ptr_r;
			end
		end
	end

	// ----------------------------------------
	// high-speed filter mode
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			hs_r <= 1'b0;
		else if (stop_det || tout_hit)
			hs_r <= 1'b0;
		else if (hs_seen)
			hs_r <= 1'b1;
	end

	// open drain: the pad output only ever pulls low
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			sda_o_r <= 1'b0;
		else
			sda_o_r <= 1'b0;
	end

	assign sda_o   = sda_o_r;
	assign sda_oe  = sda_oe_r;
	assign rd_addr = ptr_r;
	assign wr_en   = wr_en_r;
	assign wr_addr = wr_addr_r;
	assign wr_data = wr_data_r;
	assign hs_mode = hs_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	drive_state_a: assert property (@(posedge clk) disable iff (!rstn)
		sda_oe_r |-> (state_r inside {ST_ACK, ST_SEND, ST_CACK}))
		else $error("sda driven outside ack or send");
	foreign_nak_a: assert property (@(posedge clk) disable iff (!rstn)
		(got_byte && idx_r == `IDX_ADDR && byte_now[7:1] != dev_addr_r) |=> !ack_yes_r ##1 !sda_oe_r)
		else $error("foreign address acknowledged");
	nak_release_a: assert property (@(posedge clk) disable iff (!rstn)
		(state_r == ST_ACK && !ack_yes_r) |-> !sda_oe_r)
		else $error("data line driven without acknowledge");
	hs_entry_a: assert property (@(posedge clk) disable iff (!rstn)
		(hs_seen && !stop_det && !tout_hit && !start_det) |=> hs_r && !ack_yes_r)
		else $error("high-speed code mishandled");
	hs_exit_a: assert property (@(posedge clk) disable iff (!rstn)
		stop_det |=> !hs_r && state_r == ST_IDLE)
		else $error("stop did not leave high-speed mode");
	lockup_a: assert property (@(posedge clk) disable iff (!rstn)
		tout_hit |=> state_r == ST_IDLE && !sda_oe_r)
		else $error("timeout did not reset bus state");
	write_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
		wr_en_r |-> wr_addr_r == ptr_r ##1 !wr_en_r)
		else $error("register write malformed");
	ptr_hold_a: assert property (@(posedge clk) disable iff (!rstn)
		(ptr_r != $past(ptr_r)) |-> $past(ptr_load || restore || burst_inc))
		else $error("pointer changed without cause");
	burst_step_a: assert property (@(posedge clk) disable iff (!rstn)
		(burst_inc && !ptr_load && !restore) |=> ptr_r == $past(ptr_r) + 8'h01)
		else $error("burst pointer did not advance");
	burst_back_a: assert property (@(posedge clk) disable iff (!rstn)
		restore |=> ptr_r == $past(save_r) && !burst_act_r)
		else $error("pointer not restored at stop");
	start_clear_a: assert property (@(posedge clk) disable iff (!rstn)
		(start_det && !tout_hit && !stop_det) |=> state_r == ST_RECV && !sda_oe_r)
		else $error("start did not restart reception");

endmodule : target_port

// [target_map.svh]
`ifndef TARGET_MAP_SVH
`define TARGET_MAP_SVH

// strapped target addresses
`define ADDR_GND    7'h44
`define ADDR_VDD    7'h45
`define ADDR_SDA    7'h46
`define ADDR_SCL    7'h45

// address-select pin connection codes
`define STRAP_GND   2'h0
`define STRAP_VDD   2'h1
`define STRAP_SDA   2'h2
`define STRAP_SCL   2'h3

// high-speed controller code, upper five bits
`define HS_CODE     5'h01

// byte phases of a write transfer
`define IDX_ADDR    3'h0
`define IDX_PTR     3'h1
`define IDX_WHI     3'h2
`define IDX_WLO     3'h3
`define IDX_OVER    3'h4

`define LAST_BIT    3'h7
`define PTR_RST     8'h00

// bus speeds in kHz
`define SM_MAX_KHZ  100
`define FM_MAX_KHZ  400
`define HS_MAX_KHZ  2600

// lockup timeout
`define TOUT_MS     28
`define NS_PER_MS   1000000
`define CLK_NS      25

`endif

// [target_pkg.sv]
package target_pkg;

	typedef logic [7:0]  byte_type;
	typedef logic [15:0] word_type;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_RECV = 6'h02,
		ST_ACK  = 6'h04,
		ST_SEND = 6'h08,
		ST_CACK = 6'h10,
		ST_SKIP = 6'h20
	} state_type;

endpackage : target_pkg

// [bus_ctl.sv]
module bus_ctl (
	// bus wires
	output logic      scl,
	output logic      sda_pull,
	input  wire logic sda
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// bus controller model
	// ----------------------------------------
	// half period 310 ns: slow enough for the spike filter, and off the clk grid
	localparam time H = 310ns;

	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	// data moves only in the low half of scl; sampled at the end of the high half
	task automatic bit_x(input logic b, output logic r);
		#(H / 2);
		sda_pull = ~b;
		#(H / 2);
		scl = 1'b1;
		#H;
		r = sda;
		scl = 1'b0;
	endtask : bit_x

	// also serves as the repeated start
	task automatic start;
		#(H / 2);
		sda_pull = 1'b0;
		#(H / 2);
		scl = 1'b1;
		#H;
		sda_pull = 1'b1;
		#H;
		scl = 1'b0;
	endtask : start

	// scl then stands high until the next frame
	task automatic stop;
		#(H / 2);
		sda_pull = 1'b1;
		#(H / 2);
		scl = 1'b1;
		#H;
		sda_pull = 1'b0;
		#H;
	endtask : stop

	// eight bits then the acknowledge slot; d of all ones releases the line for reads
	task automatic xfer(input target_pkg::byte_type d, input logic a9,
		output target_pkg::byte_type q, output logic r9);
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], q[i]);
		end
		bit_x(a9, r9);
	endtask : xfer
endmodule : bus_ctl

// [tb.sv]
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import target_pkg::*;

	logic       clk        = 1'b0;
	logic       rstn       = 1'b1;
	logic       burst_en   = 1'b0;
	logic [1:0] addr_strap = 2'h0;
	word_type   rd_data    = 16'h0000;
	logic       scl;
	logic       sda_pull;
	wire logic  sda;
	logic       sda_o;
	logic       sda_oe;
	logic       wr_en;
	logic       hs_mode;
	byte_type   rd_addr;
	byte_type   wr_addr;
	word_type   wr_data;
	byte_type   wa;
	word_type   wd;
	logic [15:0] wcount;
	byte_type   lf         = 8'h5b;
	int         fail_count = 0;
	int         checked    = 0;

	always #12.5 clk = ~clk;
	// open drain wire with pull-up
	// the device pulls low only when it enables its pad and the pad value is low
	assign sda = (sda_pull | (sda_oe & ~sda_o)) ? 1'b0 : 1'b1;

	target_port #(.TOUT_CYC(200)) target_port_i (.clk(clk), .rstn(rstn), .scl(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe), .addr_strap(addr_strap), .burst_en(burst_en), .rd_data(rd_data),
		.rd_addr(rd_addr), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .hs_mode(hs_mode));
	bus_ctl ctl_i (.scl(scl), .sda_pull(sda_pull), .sda(sda));

	// ----------------------------------------
	// expectations
	// ----------------------------------------
	function automatic byte_type nx(input byte_type x);
		nx = {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction : nx

	function automatic logic [6:0] adr(input logic [1:0] s);
		case (s)
			2'h0: adr = 7'h44;
			2'h1: adr = 7'h45;
			2'h2: adr = 7'h46;
			default: adr = 7'h45;
		endcase
	endfunction : adr

	function automatic word_type word_of(input byte_type p);
		word_of = {p ^ 8'ha5, ~p};
	endfunction : word_of

	always @(negedge clk) rd_data <= word_of(rd_addr);

	always @(posedge clk) begin
		if (wr_en === 1'b1) begin
			wcount <= wcount + 16'h0001;
			wa <= wr_addr;
			wd <= wr_data;
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic send(input byte_type b, output logic ack);
		byte_type q;
		logic     r;
		ctl_i.xfer(b, 1'b1, q, r);
		ack = ~r;
	endtask : send

	// two words, controller acks all but the last byte
	task automatic rd2(input logic [6:0] ad, output word_type w0, output word_type w1);
		byte_type q [4];
		logic     r;
		ctl_i.start;
		send({ad, 1'b1}, r);
		chk(16'(r), 16'h0001);
		for (int k = 0; k < 4; k++) begin
			ctl_i.xfer(8'hff, k == 3, q[k], r);
		end
		ctl_i.stop;
		w0 = {q[0], q[1]};
		w1 = {q[2], q[3]};
	endtask : rd2

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up

	initial begin
		#2ms;
		fail_count++;
		wrap_up;
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		byte_type p;
		byte_type h;
		byte_type l;
		logic     a;
		word_type w0;
		word_type w1;
		// a real falling edge on rstn, so the link-clock flops are reset even without a bus clock edge
		#1 rstn = 1'b0;
		repeat (2) @(posedge clk);
		chk(16'({sda_oe, hs_mode, wr_en}), 16'h0000);
		@(negedge clk) rstn = 1'b1;
		repeat (6) @(posedge clk);
		for (int s = 0; s < 4; s++) begin
			@(negedge clk) addr_strap = 2'(s);
			lf = nx(lf);
			p = lf;
			lf = nx(lf);
			h = lf;
			lf = nx(lf);
			l = lf;
			wcount = 16'h0000;
			ctl_i.start;
			send({adr(2'(s)), 1'b0}, a);
			chk(16'(a), 16'h0001);
			send(p, a);
			chk(16'(a), 16'h0001);
			send(h, a);
			chk(16'(a), 16'h0001);
			send(l, a);
			chk(16'(a), 16'h0001);
			send(8'h3c, a);
			chk(16'(a), 16'h0000);
			ctl_i.stop;
			repeat (10) @(posedge clk);
			chk(wcount, 16'h0001);
			chk({wa, 8'h00}, {p, 8'h00});
			chk(wd, {h, l});
			chk(16'(rd_addr), 16'(p));
			ctl_i.start;
			send({adr(2'(s)) ^ 7'h03, 1'b0}, a);
			chk(16'(a), 16'h0000);
			send(8'h11, a);
			chk(16'(a), 16'h0000);
			ctl_i.stop;
			chk(wcount, 16'h0001);
			rd2(adr(2'(s)), w0, w1);
			chk(w0, word_of(p));
			chk(w1, word_of(p));
		end
		// partial write then burst read
		lf = nx(lf);
		p = lf;
		ctl_i.start;
		send({adr(2'h1), 1'b0}, a);
		chk(16'(a), 16'h0001);
		send(p, a);
		chk(16'(a), 16'h0001);
		ctl_i.stop;
		@(negedge clk) burst_en = 1'b1;
		rd2(adr(2'h1), w0, w1);
		repeat (20) @(posedge clk);
		chk(w0, word_of(p));
		chk(w1, word_of(p + 8'h01));
		chk(16'(rd_addr), 16'(p));
		@(negedge clk) burst_en = 1'b0;
		// high-speed entry, kept by repeated start, left by stop
		ctl_i.start;
		send(8'h0d, a);
		chk(16'(a), 16'h0000);
		chk(16'(hs_mode), 16'h0001);
		ctl_i.start;
		send({adr(2'h1), 1'b0}, a);
		chk(16'(a), 16'h0001);
		ctl_i.start;
		chk(16'(hs_mode), 16'h0001);
		ctl_i.stop;
		repeat (20) @(posedge clk);
		chk(16'(hs_mode), 16'h0000);
		// clock held low ends the transfer
		ctl_i.start;
		send(8'h0f, a);
		chk(16'(hs_mode), 16'h0001);
		repeat (300) @(posedge clk);
		chk(16'({hs_mode, sda_oe}), 16'h0000);
		chk(16'(sda_o), 16'h0000);
		ctl_i.stop;
		wrap_up;
	end
endmodule : tb
